// >>> shared/dmpc_regs.vh
// Register indices, field positions, reset values and serial frame counts
`ifndef DMPC_REGS_VH
`define DMPC_REGS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define DMPC_IDX_CONFIG   6'h00
`define DMPC_IDX_STATUS   6'h01
`define DMPC_IDX_SAMPLE   6'h02

// ----------------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------------
`define DMPC_CFG_PHASE    0
`define DMPC_CFG_TWOS     1
`define DMPC_CFG_PD       2
`define DMPC_CFG_I_INTERNAL_SET_RESISTOR    3
`define DMPC_CFG_Q_INTERNAL_SET_RESISTOR    4
`define DMPC_CFG_W        5
`define DMPC_CFG_RESET    5'h00

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define DMPC_ST_MODE      0
`define DMPC_ST_PHASE     1
`define DMPC_ST_TWOS      2
`define DMPC_ST_PD        3
`define DMPC_ST_ARMED     4
`define DMPC_ST_W         5

// ----------------------------------------------------------------------
// Serial frame: 8 instruction bits then 8 data bits, MSB first
// ----------------------------------------------------------------------
`define DMPC_SP_INSTR_LAST 5'd7
`define DMPC_SP_DATA_FIRST 5'd8
`define DMPC_SP_LAST       5'd15
`define DMPC_SP_BITS       5'd16
`define DMPC_SP_RW_BIT     6

`endif

// >>> logic/dmpc_sync.v
// Two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ps

module dmpc_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk_i,   // Sampling clock
  input  wire             rst_i,   // Async reset, active high
  input  wire [WIDTH-1:0] async_i, // Inputs from another domain
  output reg  [WIDTH-1:0] sync_o   // Second stage, safe to use
);

  reg [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta   <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule // dmpc_sync

// >>> logic/dmpc_serial.v
// Serial port slave: instruction byte then one data byte per frame
`timescale 1ns/1ps
`include "dmpc_regs.vh"

module dmpc_serial (
  input  wire       clk_i,       // System clock
  input  wire       rst_i,       // Async reset, active high
  input  wire       enable_i,    // Serial-register mode active
  input  wire       sclk_i,      // Synchronised serial clock
  input  wire       cs_n_i,      // Synchronised select, active low
  input  wire       sdio_i,      // Synchronised data line
  input  wire [7:0] rd_data_i,   // Read data for addr_o
  output reg  [4:0] addr_o,      // Register index of the frame
  output reg        wr_o,        // One-cycle write strobe
  output reg  [7:0] wr_data_o,   // Write data
  output reg        sdio_o,      // Data line drive value
  output reg        sdio_oe_n_o  // Data line enable, low drives
);

  reg       sclk_q;
  reg [4:0] cnt;
  reg [7:0] shreg;
  reg [7:0] tx;
  reg       rd_mode;
  reg       load;

  wire rise   = sclk_i & ~sclk_q;
  wire fall   = ~sclk_i & sclk_q;
  wire active = enable_i & ~cs_n_i;

  // Bit engine; a dropped select aborts the frame and frees the line
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_q      <= 1'b0;
      cnt         <= 5'd0;
      shreg       <= 8'h00;
      tx          <= 8'h00;
      rd_mode     <= 1'b0;
      load        <= 1'b0;
      addr_o      <= 5'h00;
      wr_o        <= 1'b0;
      wr_data_o   <= 8'h00;
      sdio_o      <= 1'b0;
      sdio_oe_n_o <= 1'b1;
    end else begin
      sclk_q <= sclk_i;
      wr_o   <= 1'b0;
      load   <= 1'b0;
      // Read data is fetched a cycle after the index settles
      if (load) begin
        tx <= rd_data_i;
      end
      if (!active) begin
        cnt         <= 5'd0;
        rd_mode     <= 1'b0;
        sdio_oe_n_o <= 1'b1;
      end else if (rise && cnt < `DMPC_SP_BITS) begin
        shreg <= {shreg[6:0], sdio_i};
        cnt   <= cnt + 5'd1;
        if (cnt == `DMPC_SP_INSTR_LAST) begin
          rd_mode <= shreg[`DMPC_SP_RW_BIT];
          load    <= shreg[`DMPC_SP_RW_BIT];
          addr_o  <= {shreg[3:0], sdio_i};
        end
        if (cnt == `DMPC_SP_LAST && !rd_mode) begin
          wr_o      <= 1'b1;
          wr_data_o <= {shreg[6:0], sdio_i};
        end
      end else if (fall && rd_mode && cnt >= `DMPC_SP_DATA_FIRST &&
                   cnt < `DMPC_SP_BITS) begin
        sdio_o      <= tx[7];
        tx          <= {tx[6:0], 1'b0};
        sdio_oe_n_o <= 1'b0;
      end
    end
  end

endmodule // dmpc_serial

// >>> logic/dmpc_top.v
// Converter mode and shared-pin configuration control with Wishbone slave
//
// Summary of operation
// - Strap low selects serial-register configuration mode.
// - Strap high selects pin-strap configuration mode.
// - A high pulse on the strap restores all configuration defaults.
// - Serial mode: shared clock pin is the serial port clock.
// - Serial mode: shared data pin is one bidirectional data line.
// - Serial mode: shared select pin is active-low frame qualifier.
// - Pin mode: retime pin sets the internal retime clock phase.
// - Distinct clocks: rising edge on retime pin triggers retime.
// - Pin mode: format pin low means straight binary samples.
// - Pin mode: format pin high means two's complement samples.
// - Pin mode: power-down pin high stops all but serial port.
// - Internal set resistor enable turns adjust pin into aux output.
// - Data-qualify clock captures the parallel sample words.
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "dmpc_regs.vh"

module dmpc_top #(
  parameter DATA_W = 12
) (
  input  wire              CLK_SYS_I,          // System clock, 250 MHz
  input  wire              SYS_RST_I,          // Async reset, active high
  // Wishbone classic slave
  input  wire [7:0]        WB_ADR_I,           // Byte address
  input  wire [31:0]       WB_DAT_I,           // Write data
  input  wire [3:0]        WB_SEL_I,           // Byte enables
  input  wire              WB_WE_I,            // Write enable
  input  wire              WB_CYC_I,           // Bus cycle
  input  wire              WB_STB_I,           // Strobe
  output reg  [31:0]       WB_DAT_O,           // Read data
  output reg               WB_ACK_O,           // Acknowledge
  // Strap and shared pins
  input  wire              MODE_SELECT_I,      // Mode strap / reset pulse
  input  wire              SHARED_CLK_I,       // Serial clock / retime
  input  wire              SHARED_DATA_I,      // Serial data / format in
  output wire              SHARED_DATA_O,      // Serial data drive value
  output wire              SHARED_DATA_OE_N_O, // Low while driving
  input  wire              SHARED_SEL_I,       // Select_n / power-down
  // Converter clocks and data
  input  wire              DATA_QUALIFY_CLK_I, // Qualifies input data
  input  wire              SAMPLING_CLK_I,     // Converter sample clock
  input  wire [DATA_W-1:0] DATA_I,             // Parallel sample word
  output reg  [DATA_W-1:0] SAMPLE_O,           // Retimed binary word
  output reg               SAMPLE_VALID_O,     // One-cycle word strobe
  // Effective configuration
  output reg               PIN_STRAP_MODE_O,   // High in pin-strap mode
  output reg               RETIME_PHASE_O,     // Retime on sample clock
  output reg               TWOS_FMT_O,         // Input is two's compl.
  output reg               POWER_DOWN_O,       // Core powered down
  output reg               I_AUX_SEL_O,        // I adjust pin is aux out
  output reg               Q_AUX_SEL_O         // Q adjust pin is aux out
);

  // ----------------------------------------------------------------------
  // Register read decode shared by the bus and the serial port
  // ----------------------------------------------------------------------
  localparam SYNC_W = DATA_W + 6;

  reg [`DMPC_CFG_W-1:0] config_reg;
  reg [`DMPC_ST_W-1:0]  status_word;
  reg [DATA_W-1:0]      sample_hold;

  // Contents come in as arguments: a function that read them from the
  // module would hide them from the callers' sensitivity, and the serial
  // port, whose index rarely changes, would see a stale word
  function [31:0] reg_read;
    input [5:0]             idx;
    input [`DMPC_CFG_W-1:0] cfg;
    input [`DMPC_ST_W-1:0]  st;
    input [DATA_W-1:0]      smp;
    begin
      case (idx)
        `DMPC_IDX_CONFIG: reg_read = {{(32-`DMPC_CFG_W){1'b0}}, cfg};
        `DMPC_IDX_STATUS: reg_read = {{(32-`DMPC_ST_W){1'b0}}, st};
        `DMPC_IDX_SAMPLE: reg_read = {{(32-DATA_W){1'b0}}, smp};
        default:          reg_read = 32'h0000_0000;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  wire [SYNC_W-1:0] pins_s;
  wire [DATA_W-1:0] data_s;
  wire              strap_s;
  wire              sclk_s;
  wire              sdio_s;
  wire              sel_s;
  wire              dq_clk_s;
  wire              smp_clk_s;

  // Data and its qualify clock share one stage so they stay aligned
  dmpc_sync #(
    .WIDTH   (SYNC_W)
  ) u_sync (
    .clk_i   (CLK_SYS_I),
    .rst_i   (SYS_RST_I),
    .async_i ({DATA_I, SAMPLING_CLK_I, DATA_QUALIFY_CLK_I, SHARED_SEL_I,
               SHARED_DATA_I, SHARED_CLK_I, MODE_SELECT_I}),
    .sync_o  (pins_s)
  );

  assign strap_s   = pins_s[0];
  assign sclk_s    = pins_s[1];
  assign sdio_s    = pins_s[2];
  assign sel_s     = pins_s[3];
  assign dq_clk_s  = pins_s[4];
  assign smp_clk_s = pins_s[5];
  assign data_s    = pins_s[SYNC_W-1:6];

  // ----------------------------------------------------------------------
  // Edge history of synchronised pins
  // ----------------------------------------------------------------------
  reg strap_q;
  reg retime_q;
  reg dq_clk_q;
  reg smp_clk_q;

  always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      strap_q   <= 1'b0;
      retime_q  <= 1'b0;
      dq_clk_q  <= 1'b0;
      smp_clk_q <= 1'b0;
    end else begin
      strap_q   <= strap_s;
      retime_q  <= sclk_s;
      dq_clk_q  <= dq_clk_s;
      smp_clk_q <= smp_clk_s;
    end
  end

  wire strap_rise = strap_s & ~strap_q;
  wire retime_rise = sclk_s & ~retime_q;
  wire dq_rise    = dq_clk_s & ~dq_clk_q;
  wire smp_rise   = smp_clk_s & ~smp_clk_q;

  // ----------------------------------------------------------------------
  // Mode and effective configuration
  // ----------------------------------------------------------------------
  // Strap level chooses how the shared pins are read, every cycle
  wire pin_mode = strap_s;

  reg retime_armed;
  wire eff_phase;
  wire eff_twos;
  wire eff_pd;

  // Retime arms on the pin's rising edge, a level held low disarms it
  always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      retime_armed <= 1'b0;
    end else if (!pin_mode || !sclk_s) begin
      retime_armed <= 1'b0;
    end else if (retime_rise) begin
      retime_armed <= 1'b1;
    end
  end

  // Pin mode reads the shared pins, serial mode the register
  assign eff_phase = pin_mode ? retime_armed
                              : config_reg[`DMPC_CFG_PHASE];
  assign eff_twos  = pin_mode ? sdio_s
                              : config_reg[`DMPC_CFG_TWOS];
  assign eff_pd    = pin_mode ? sel_s
                              : config_reg[`DMPC_CFG_PD];

  // Status view of the live configuration
  always @* begin
    status_word                 = {`DMPC_ST_W{1'b0}};
    status_word[`DMPC_ST_MODE]  = pin_mode;
    status_word[`DMPC_ST_PHASE] = eff_phase;
    status_word[`DMPC_ST_TWOS]  = eff_twos;
    status_word[`DMPC_ST_PD]    = eff_pd;
    status_word[`DMPC_ST_ARMED] = retime_armed;
  end

  // ----------------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------------
  wire [4:0]  sp_addr;
  wire        sp_wr;
  wire [7:0]  sp_wr_data;
  wire [31:0] sp_word;

  assign sp_word = reg_read({1'b0, sp_addr}, config_reg, status_word,
                            sample_hold);

  // Stays live through power-down; held idle in pin-strap mode
  dmpc_serial u_serial (
    .clk_i       (CLK_SYS_I),
    .rst_i       (SYS_RST_I),
    .enable_i    (~pin_mode),
    .sclk_i      (sclk_s),
    .cs_n_i      (sel_s),
    .sdio_i      (sdio_s),
    .rd_data_i   (sp_word[7:0]),
    .addr_o      (sp_addr),
    .wr_o        (sp_wr),
    .wr_data_o   (sp_wr_data),
    .sdio_o      (SHARED_DATA_O),
    .sdio_oe_n_o (SHARED_DATA_OE_N_O)
  );

  // ----------------------------------------------------------------------
  // Wishbone classic slave
  // ----------------------------------------------------------------------
  wire       wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire       wb_wr  = wb_req & WB_WE_I & WB_SEL_I[0];
  wire [5:0] wb_idx = WB_ADR_I[7:2];

  // One-cycle answer; unmapped reads return zero, writes are dropped
  always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= wb_req;
      if (wb_req && !WB_WE_I) begin
        WB_DAT_O <= reg_read(wb_idx, config_reg, status_word, sample_hold);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------------
  // Strap pulse beats any write; bus beats serial in a tie
  always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      config_reg <= `DMPC_CFG_RESET;
    end else if (strap_rise) begin
      config_reg <= `DMPC_CFG_RESET;
    end else if (wb_wr && wb_idx == `DMPC_IDX_CONFIG) begin
      config_reg <= WB_DAT_I[`DMPC_CFG_W-1:0];
    end else if (sp_wr && {1'b0, sp_addr} == `DMPC_IDX_CONFIG) begin
      config_reg <= sp_wr_data[`DMPC_CFG_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Sample capture and retiming
  // ----------------------------------------------------------------------
  reg pending;

  // Words are converted to straight binary as they are captured;
  // while powered down nothing is captured and nothing is issued
  always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      sample_hold    <= {DATA_W{1'b0}};
      pending        <= 1'b0;
      SAMPLE_O       <= {DATA_W{1'b0}};
      SAMPLE_VALID_O <= 1'b0;
    end else begin
      SAMPLE_VALID_O <= 1'b0;
      if (eff_pd) begin
        pending <= 1'b0;
      end else begin
        if (dq_rise) begin
          sample_hold <= eff_twos ? {~data_s[DATA_W-1], data_s[DATA_W-2:0]}
                                  : data_s;
          pending     <= 1'b1;
        end
        // Phase 0 issues at once, phase 1 waits for the sample clock
        if (pending && (!eff_phase || smp_rise)) begin
          SAMPLE_O       <= sample_hold;
          SAMPLE_VALID_O <= 1'b1;
          if (!dq_rise) begin
            pending <= 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registered configuration outputs
  // ----------------------------------------------------------------------
  // Aux selection comes from the register and is gated off in pin mode,
  // so pin mode keeps the external full-scale adjust connection
  always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      PIN_STRAP_MODE_O <= 1'b0;
      RETIME_PHASE_O   <= 1'b0;
      TWOS_FMT_O       <= 1'b0;
      POWER_DOWN_O     <= 1'b0;
      I_AUX_SEL_O      <= 1'b0;
      Q_AUX_SEL_O      <= 1'b0;
    end else begin
      PIN_STRAP_MODE_O <= pin_mode;
      RETIME_PHASE_O   <= eff_phase;
      TWOS_FMT_O       <= eff_twos;
      POWER_DOWN_O     <= eff_pd;
      I_AUX_SEL_O      <= ~pin_mode & config_reg[`DMPC_CFG_I_INTERNAL_SET_RESISTOR];
      Q_AUX_SEL_O      <= ~pin_mode & config_reg[`DMPC_CFG_Q_INTERNAL_SET_RESISTOR];
    end
  end

endmodule // dmpc_top

// >>> verification/dmpc_host_model.sv
// Behavioural host and strap driver for the shared pins
`timescale 1ns/1ps

module dmpc_host_model (
  input  wire clk_i,      // System clock, times the link
  input  wire dev_d_i,    // Device data drive value
  input  wire dev_oe_n_i, // Device drive enable, low drives
  output reg  sclk_o,     // Serial clock or retime pin
  output reg  sel_n_o,    // Select, or power-down in pin mode
  output wire line_o      // Resolved level of the data wire
);
  reg host_d; // Host drive value

  // No pull on the wire: a released host keeps toggling its value
  assign line_o = dev_oe_n_i ? host_d : dev_d_i;

  // Idle link: clock still and low, select high
  initial begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    host_d = 1'b0;
  end

  // Pin-strap levels: retime, format, power-down
  task pins(input c, input f, input p);
    begin
      @(posedge clk_i);
      sclk_o <= c;
      host_d <= f;
      sel_n_o <= p;
    end
  endtask

  // One 16-bit frame, MSB first; link period is eight system cycles
  task frame(input rd, input [4:0] idx, input [7:0] wd,
             output [7:0] q);
    reg [15:0] sh;
    integer    i;
    begin
      sh = {rd, 2'b00, idx, wd};
      q = 8'h00;
      @(posedge clk_i);
      sel_n_o <= 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
        sclk_o <= 1'b0;
        host_d <= (rd && i > 7) ? ~host_d : sh[15-i];
        repeat (4) @(posedge clk_i);
        sclk_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        // Late in the high phase, long after the device updates
        if (i > 7)
          q[15-i] = line_o;
      end
      sel_n_o <= 1'b1;
      sclk_o <= 1'b0;
      repeat (8) @(posedge clk_i);
    end
  endtask
endmodule // dmpc_host_model

// >>> verification/dmpc_top_assertions.sv
// Port-level assertions for the mode and shared-pin control block
`timescale 1ns/1ps

module dmpc_top_assertions #(
  parameter DATA_W = 12 // Sample width, not watched here
) (
  input wire CLK_SYS_I,          // Clock
  input wire SYS_RST_I,          // Reset
  input wire WB_CYC_I,           // Bus cycle
  input wire WB_STB_I,           // Strobe
  input wire WB_ACK_O,           // Acknowledge
  input wire MODE_SELECT_I,      // Strap
  input wire SHARED_CLK_I,       // Retime pin
  input wire SHARED_DATA_I,      // Format pin
  input wire SHARED_SEL_I,       // Select or power-down
  input wire SHARED_DATA_OE_N_O, // Data drive, low
  input wire SAMPLE_VALID_O,     // Word strobe
  input wire PIN_STRAP_MODE_O,   // Pin mode
  input wire RETIME_PHASE_O,     // Phase
  input wire TWOS_FMT_O,         // Format
  input wire POWER_DOWN_O,       // Power-down
  input wire I_AUX_SEL_O,        // I aux
  input wire Q_AUX_SEL_O         // Q aux
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  ack_after_req_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
    |=> WB_ACK_O) else $error("no ack after request");
  ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  ack_has_req_a: assert property (WB_ACK_O |->
    $past(WB_CYC_I) && $past(WB_STB_I)) else $error("ack without request");

  // ----------------------------------------------------------------
  // Mode and shared pins; settling margin covers sync latency
  // ----------------------------------------------------------------
  mode_tracks_a: assert property ($stable(MODE_SELECT_I)[*6] |->
    PIN_STRAP_MODE_O == MODE_SELECT_I) else $error("mode not tracked");
  fmt_pin_a: assert property ((MODE_SELECT_I && $stable(SHARED_DATA_I))[*7]
    |-> TWOS_FMT_O == SHARED_DATA_I) else $error("format not from pin");
  pd_pin_a: assert property ((MODE_SELECT_I && $stable(SHARED_SEL_I))[*7]
    |-> POWER_DOWN_O == SHARED_SEL_I) else $error("power-down not from pin");
  retime_arm_a: assert property ($rose(SHARED_CLK_I) && MODE_SELECT_I
    && PIN_STRAP_MODE_O |-> ##[1:6] RETIME_PHASE_O)
    else $error("retime not armed by edge");
  retime_low_a: assert property ((MODE_SELECT_I && !SHARED_CLK_I)[*7]
    |-> !RETIME_PHASE_O) else $error("retime armed with pin low");
  aux_pin_mode_a: assert property (PIN_STRAP_MODE_O[*5]
    |-> !I_AUX_SEL_O && !Q_AUX_SEL_O) else $error("aux set in pin mode");
  no_drive_idle_a: assert property ((MODE_SELECT_I || SHARED_SEL_I)[*5]
    |-> SHARED_DATA_OE_N_O) else $error("data driven while idle");

  // ----------------------------------------------------------------
  // Sample path
  // ----------------------------------------------------------------
  valid_pulse_a: assert property (SAMPLE_VALID_O |=> !SAMPLE_VALID_O)
    else $error("valid longer than one cycle");
  pd_no_word_a: assert property (POWER_DOWN_O[*3] |-> !SAMPLE_VALID_O)
    else $error("word issued while powered down");

  cover property (WB_ACK_O);
  cover property (SAMPLE_VALID_O);
  cover property (!SHARED_DATA_OE_N_O);
  cover property ($rose(RETIME_PHASE_O));
endmodule // dmpc_top_assertions

bind dmpc_top dmpc_top_assertions #(.DATA_W(DATA_W)) u_chk (
  .CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .MODE_SELECT_I(MODE_SELECT_I),
  .SHARED_CLK_I(SHARED_CLK_I), .SHARED_DATA_I(SHARED_DATA_I),
  .SHARED_SEL_I(SHARED_SEL_I), .SHARED_DATA_OE_N_O(SHARED_DATA_OE_N_O),
  .SAMPLE_VALID_O(SAMPLE_VALID_O), .PIN_STRAP_MODE_O(PIN_STRAP_MODE_O),
  .RETIME_PHASE_O(RETIME_PHASE_O), .TWOS_FMT_O(TWOS_FMT_O),
  .POWER_DOWN_O(POWER_DOWN_O), .I_AUX_SEL_O(I_AUX_SEL_O),
  .Q_AUX_SEL_O(Q_AUX_SEL_O));

// >>> verification/dmpc_top_bench.sv
// Self-checking bench for the mode and shared-pin control block
`timescale 1ns/1ps

module dmpc_top_bench;
  localparam DW = 12;
  reg           clk, rst, cyc, stb, we, strap, dq, smp;
  reg  [2:0]    sc;
  reg  [7:0]    adr, q, v;
  reg  [31:0]   wdat, r;
  reg  [3:0]    sel;
  reg  [DW-1:0] din;
  wire [31:0]   rdat;
  wire [DW-1:0] sout;
  wire          ack, dev_d, dev_oe_n, sclk, seln, line, vld;
  wire          pmode, ph, twos, pd, iaux, qaux;
  integer       err_count, check_count, seed, i, n;

  dmpc_top #(.DATA_W(DW)) u_dut (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .WB_ADR_I(adr), .WB_DAT_I(wdat),
    .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .MODE_SELECT_I(strap),
    .SHARED_CLK_I(sclk), .SHARED_DATA_I(line), .SHARED_DATA_O(dev_d),
    .SHARED_DATA_OE_N_O(dev_oe_n), .SHARED_SEL_I(seln),
    .DATA_QUALIFY_CLK_I(dq), .SAMPLING_CLK_I(smp), .DATA_I(din),
    .SAMPLE_O(sout), .SAMPLE_VALID_O(vld), .PIN_STRAP_MODE_O(pmode),
    .RETIME_PHASE_O(ph), .TWOS_FMT_O(twos), .POWER_DOWN_O(pd),
    .I_AUX_SEL_O(iaux), .Q_AUX_SEL_O(qaux));

  dmpc_host_model u_host (.clk_i(clk), .dev_d_i(dev_d),
    .dev_oe_n_i(dev_oe_n), .sclk_o(sclk), .sel_n_o(seln), .line_o(line));

  // 250 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Free-running sampling clock, 32 ns period
  always @(posedge clk) begin
    sc <= sc + 3'd1;
    smp <= sc[2];
  end

  // Expected straight-binary word: two's complement flips the MSB
  function [31:0] exp_word(input [DW-1:0] d, input t);
    exp_word = {{(32-DW){1'b0}}, d ^ {t, {(DW-1){1'b0}}}};
  endfunction

  task chk(input [8*10:1] nm, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
      end
    end
  endtask

  task complete_run;
    begin
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // Classic single cycle; request held until ack is sampled high
  task wb(input w, input [7:0] a, input [31:0] d, input [3:0] s);
    begin
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
      n = 0;
      @(posedge clk);
      while (ack !== 1'b1 && n < 20) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n == 20) begin
        chk("ack", 1, ack);
        complete_run;
      end
      r = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge clk);
    end
  endtask

  // Pin paths pass two sync flops plus edge logic
  task settle;
    repeat (8) @(posedge clk);
  endtask

  // One qualify edge with word d; e says whether a word must issue
  task qual(input [DW-1:0] d, input t, input e);
    reg           got;
    reg [DW-1:0] s;
    begin
      got = 1'b0;
      s = {DW{1'b0}};
      din <= d; dq <= 1'b1;
      for (n = 0; n < 30; n = n + 1) begin
        @(posedge clk);
        if (n == 6) dq <= 1'b0;
        if (vld === 1'b1) begin
          got = 1'b1;
          s = sout;
        end
      end
      chk("valid", e, got);
      if (e) begin
        chk("sample", exp_word(d, t), s);
        wb(0, 8'h08, 0, 4'hf);
        chk("sample reg", exp_word(d, t), r);
      end
    end
  endtask

  initial begin
    seed = 32'ha302; err_count = 0; check_count = 0; sc = 3'd0; smp = 0;
    rst = 1; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0; sel = 0;
    strap = 0; dq = 0; din = 0;
    repeat (16) @(posedge clk);
    chk("oe_n rst", 1, dev_oe_n);
    rst <= 1'b0;
    settle;
    chk("pin mode", 0, pmode);
    wb(0, 8'h00, 0, 4'hf);
    chk("cfg reset", 0, r);
    // Random configs over the bus drive the effective outputs
    for (i = 0; i < 6; i = i + 1) begin
      v = $random(seed) & 8'h1f;
      wb(1, 8'h00, {24'h0, v}, 4'h1);
      wb(0, 8'h00, 0, 4'hf);
      chk("cfg rd", v, r);
      settle;
      chk("eff cfg", v, {qaux, iaux, pd, twos, ph});
      wb(0, 8'h04, 0, 4'hf);
      chk("status", {1'b0, v[2:0], 1'b0}, r[4:0]);
    end
    wb(1, 8'h00, 32'h1f, 4'he);
    wb(0, 8'h00, 0, 4'hf);
    chk("sel gate", v, r);
    wb(1, 8'h3c, 32'hff, 4'hf);
    wb(0, 8'h3c, 0, 4'hf);
    chk("unmapped", 0, r);
    // Serial writes checked over the bus, then read back serially
    for (i = 0; i < 4; i = i + 1) begin
      v = $random(seed) & 8'h1f;
      u_host.frame(1'b0, 5'h00, v, q);
      wb(0, 8'h00, 0, 4'hf);
      chk("spi wr", v, r);
      u_host.frame(1'b1, 5'h00, 8'h00, q);
      chk("spi rd", v, q);
    end
    // Phase and format from config, then power-down blocks words
    for (i = 0; i < 5; i = i + 1) begin
      wb(1, 8'h00, (i == 4) ? 32'h4 : i, 4'h1);
      settle;
      qual($random(seed), i[1], i != 4);
    end
    wb(1, 8'h00, 32'h1f, 4'h1);
    strap <= 1'b1;
    repeat (4) @(posedge clk);
    strap <= 1'b0;
    settle;
    wb(0, 8'h00, 0, 4'hf);
    chk("strap rst", 0, r);
    strap <= 1'b1;
    settle;
    chk("pin mode", 1, pmode);
    // Aux bits set over the bus must stay off in pin mode
    wb(1, 8'h00, 32'h18, 4'h1);
    // Every format and power-down level of the strap pins
    for (i = 0; i < 4; i = i + 1) begin
      u_host.pins(1'b0, i[0], i[1]);
      settle;
      chk("fmt pin", i[0], twos);
      chk("pd pin", i[1], pd);
      chk("aux", 0, {qaux, iaux});
      qual($random(seed), i[0], !i[1]);
    end
    u_host.pins(1'b1, 1'b0, 1'b0);
    settle;
    chk("retime", 1, ph);
    qual($random(seed), 1'b0, 1'b1);
    u_host.pins(1'b0, 1'b0, 1'b0);
    settle;
    chk("retime", 0, ph);
    strap <= 1'b0;
    settle;
    chk("pin mode", 0, pmode);
    complete_run;
  end
endmodule // dmpc_top_bench
